/* File: hw/ofc_pkg.sv */
// output format control package: register map, fields, encodings
package ofc_pkg;
  //==========================================================================
  //==========================================================================
  localparam int OFC_AW = 9;
  localparam logic [8:0] OFC_FMT_ADDR = 9'h19B;
  localparam logic [8:0] OFC_STAT_ADDR = 9'h1F0;
  localparam logic [15:0] OFC_FMT_RESET = 16'h0200;
  localparam int OFC_BAYER_BIT = 14;
  localparam int OFC_SYNC_BIT = 11;
  localparam int OFC_BYPASS_BIT = 10;
  localparam int OFC_INV_BIT = 9;
  localparam int OFC_RGB_BIT = 8;
  localparam int OFC_RGBF_LO = 6;
  localparam int OFC_RAMP_LO = 4;
  localparam int OFC_SHIFT_BIT = 3;
  localparam int OFC_SHIFT_AMT = 3;
  localparam int OFC_STAT_BUSY_BIT = 0;
  localparam int OFC_STAT_FRM_LO = 8;
  localparam logic [7:0] OFC_SAV_XY = 8'h80;
  localparam logic [7:0] OFC_EAV_XY = 8'h9D;
  localparam logic [7:0] OFC_PRE_FF = 8'hFF;
  localparam logic [7:0] OFC_PRE_00 = 8'h00;
  typedef enum logic [1:0] {
    OFC_RGB565 = 2'h0, OFC_RGB555 = 2'h1, OFC_RGB444X = 2'h2, OFC_RGBX444 = 2'h3
  } ofc_rgb_t;
  typedef enum logic [1:0] {
    OFC_RAMP_OFF = 2'h0, OFC_RAMP_COL = 2'h1, OFC_RAMP_ROW = 2'h2, OFC_RAMP_FRM = 2'h3
  } ofc_ramp_t;
  typedef enum logic [2:0] {
    OFC_L_IDLE = 3'h0, OFC_L_SAV = 3'h1, OFC_L_HI = 3'h2, OFC_L_LO = 3'h3, OFC_L_EAV = 3'h4
  } ofc_link_t;
endpackage

/* File: hw/ofc_format.sv */
// output format control, context B: formatter, crossing and byte link
`timescale 1ns/10ps
module ofc_format #(
  parameter int RAW_W = 10,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // register port
  input wire logic [ofc_pkg::OFC_AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  // pixel stream from the pipeline
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic pix_sof,
  input wire logic pix_sol,
  input wire logic pix_eol,
  input wire logic [RAW_W-1:0] pix_raw,
  input wire logic [RAW_W-1:0] pix_bayer,
  input wire logic [7:0] pix_r,
  input wire logic [7:0] pix_g,
  input wire logic [7:0] pix_b,
  input wire logic [7:0] pix_y,
  input wire logic [7:0] pix_c,
  // statistics tap for exposure and white balance
  output logic stat_valid,
  output logic [7:0] stat_r,
  output logic [7:0] stat_g,
  output logic [7:0] stat_b,
  // link
  output logic output_pixel_clock,
  output logic [7:0] link_data,
  output logic link_valid
);
  import ofc_pkg::*;

  if (RAW_W < 9 || RAW_W > 16) begin : g_raw_w_chk $error("RAW_W must be 9..16"); end
  if (CNT_W < 8 || CNT_W > 16) begin : g_cnt_w_chk $error("CNT_W must be 8..16"); end

  //==========================================================================
  // helpers
  // codes 00 and FF are kept for sync words, so components are clipped off them when embedded; packed RGB, raw and bayer words can still hold them
  function automatic logic [7:0] prep(input logic [7:0] v, input logic ramp_on,
                                      input logic [7:0] ramp_v, input logic shift,
                                      input logic clip);
    logic [7:0] t;
    t = ramp_on ? ramp_v : v;
    if (shift) t = {t[7-OFC_SHIFT_AMT:0], {OFC_SHIFT_AMT{1'b0}}};
    if (clip && t == OFC_PRE_FF) t = 8'hFE;
    else if (clip && t == OFC_PRE_00) t = 8'h01;
    prep = t;
  endfunction
  function automatic logic [15:0] split(input logic [RAW_W-1:0] s);
    split = {s[RAW_W-1:RAW_W-8], 8'(s[RAW_W-9:0])};
  endfunction
  function automatic logic [7:0] sync_byte(input logic [1:0] idx, input logic [7:0] xy);
    case (idx)
      2'h0: sync_byte = OFC_PRE_FF;
      2'h3: sync_byte = xy;
      default: sync_byte = OFC_PRE_00;
    endcase
  endfunction

  //==========================================================================
  // registers
  logic [15:0] fmt_reg;
  logic [15:0] rdata_reg;
  logic wr_seen_reg;
  logic [CNT_W-1:0] frm_reg;
  logic req_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic busy;
  // all sixteen bits are stored, undefined ones steer nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_reg <= OFC_FMT_RESET;
    end else if (reg_we && reg_addr == OFC_FMT_ADDR) begin
      fmt_reg <= reg_wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_reg <= 1'b0;
    end else if (reg_we && reg_addr == OFC_FMT_ADDR) begin
      wr_seen_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (reg_re && reg_addr == OFC_FMT_ADDR) begin
      rdata_reg <= fmt_reg;
    end else if (reg_re && reg_addr == OFC_STAT_ADDR) begin
      rdata_reg <= {frm_reg[7:0], 7'h00, busy};
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_reg;

  //==========================================================================
  // field decode
  logic bayer_on, sync_on, bypass_on, rgb_on, shift_on, ramp_on;
  ofc_rgb_t rgb_mode;
  ofc_ramp_t ramp_mode;
  assign bayer_on = fmt_reg[OFC_BAYER_BIT];
  assign sync_on = fmt_reg[OFC_SYNC_BIT];
  assign bypass_on = fmt_reg[OFC_BYPASS_BIT];
  assign rgb_on = fmt_reg[OFC_RGB_BIT];
  assign shift_on = fmt_reg[OFC_SHIFT_BIT];
  assign rgb_mode = ofc_rgb_t'(fmt_reg[OFC_RGBF_LO+:2]);
  assign ramp_mode = ofc_ramp_t'(fmt_reg[OFC_RAMP_LO+:2]);
  assign ramp_on = ramp_mode != OFC_RAMP_OFF;

  //==========================================================================
  // pixel position counters for the ramp
  logic accept;
  logic [CNT_W-1:0] col_reg, row_reg, cur_col, cur_row, cur_frm;
  logic [7:0] ramp_v;
  assign busy = req_reg != ack_s2_reg;
  assign pix_ready = !busy;
  assign accept = pix_valid && !busy;
  assign cur_col = (pix_sol || pix_sof) ? '0 : col_reg;
  assign cur_row = pix_sof ? '0 : (pix_sol ? row_reg + 1'b1 : row_reg);
  assign cur_frm = pix_sof ? frm_reg + 1'b1 : frm_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_reg <= '0;
      row_reg <= '0;
      frm_reg <= '0;
    end else if (accept) begin
      col_reg <= cur_col + 1'b1;
      row_reg <= cur_row;
      frm_reg <= cur_frm;
    end
  end
  always_comb begin
    case (ramp_mode)
      OFC_RAMP_COL: ramp_v = cur_col[7:0];
      OFC_RAMP_ROW: ramp_v = cur_row[7:0];
      OFC_RAMP_FRM: ramp_v = cur_frm[7:0];
      default: ramp_v = 8'h00;
    endcase
  end

  //==========================================================================
  // formatting
  logic [7:0] c_r, c_g, c_b, c_y, c_c;
  logic [15:0] word;
  assign c_r = prep(pix_r, ramp_on, ramp_v, shift_on, sync_on);
  assign c_g = prep(pix_g, ramp_on, ramp_v, shift_on, sync_on);
  assign c_b = prep(pix_b, ramp_on, ramp_v, shift_on, sync_on);
  assign c_y = prep(pix_y, ramp_on, ramp_v, shift_on, sync_on);
  assign c_c = prep(pix_c, ramp_on, ramp_v, shift_on, sync_on);
  always_comb begin
    if (bypass_on) begin
      word = split(pix_raw);
    end else if (bayer_on) begin
      word = split(pix_bayer);
    end else if (rgb_on) begin
      case (rgb_mode)
        OFC_RGB565: word = {c_r[7:3], c_g[7:2], c_b[7:3]};
        OFC_RGB555: word = {1'b0, c_r[7:3], c_g[7:3], c_b[7:3]};
        OFC_RGB444X: word = {c_r[7:4], c_g[7:4], c_b[7:4], 4'h0};
        default: word = {4'h0, c_r[7:4], c_g[7:4], c_b[7:4]};
      endcase
    end else begin
      word = {c_c, c_y};
    end
  end

  //==========================================================================
  // statistics tap: always the pipeline components, whatever leaves the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_valid <= 1'b0;
      stat_r <= 8'h00;
      stat_g <= 8'h00;
      stat_b <= 8'h00;
    end else begin
      stat_valid <= pix_valid && pix_ready;
      if (pix_valid && pix_ready) begin
        stat_r <= pix_r;
        stat_g <= pix_g;
        stat_b <= pix_b;
      end
    end
  end

  //==========================================================================
  // crossing: held word plus toggle handshake, one pixel in flight
  logic [15:0] xw_reg;
  logic xsol_reg, xeol_reg, xsync_reg;
  logic ack_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xw_reg <= 16'h0000;
      xsol_reg <= 1'b0;
      xeol_reg <= 1'b0;
      xsync_reg <= 1'b0;
      req_reg <= 1'b0;
    end else if (accept) begin
      xw_reg <= word;
      xsol_reg <= pix_sol || pix_sof;
      xeol_reg <= pix_eol;
      xsync_reg <= sync_on;
      req_reg <= !req_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  //==========================================================================
  // link domain
  logic req_s1_reg, req_s2_reg, inv_s1_reg, inv_s2_reg;
  logic [15:0] lw_reg;
  logic leol_reg, lsync_reg;
  logic [1:0] idx_reg;
  ofc_link_t lstate_reg;
  logic new_word;
  assign new_word = req_s2_reg != ack_reg;
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      inv_s1_reg <= 1'b1;
      inv_s2_reg <= 1'b1;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      inv_s1_reg <= fmt_reg[OFC_INV_BIT];
      inv_s2_reg <= inv_s1_reg;
    end
  end
  // data always launches on the rising link clock; inverting the clock pin
  // moves that launch onto the falling pin edge. a setting change may glitch
  assign output_pixel_clock = link_clk ^ inv_s2_reg;
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      lw_reg <= 16'h0000;
      leol_reg <= 1'b0;
      lsync_reg <= 1'b0;
    end else if (lstate_reg == OFC_L_IDLE && new_word) begin
      ack_reg <= req_s2_reg;
      lw_reg <= xw_reg;
      leol_reg <= xeol_reg;
      lsync_reg <= xsync_reg;
    end
  end
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lstate_reg <= OFC_L_IDLE;
      idx_reg <= 2'h0;
      link_data <= 8'h00;
      link_valid <= 1'b0;
    end else begin
      case (lstate_reg)
        OFC_L_IDLE: begin
          link_data <= 8'h00;
          link_valid <= 1'b0;
          idx_reg <= 2'h0;
          if (new_word) begin
            lstate_reg <= (xsol_reg && xsync_reg) ? OFC_L_SAV : OFC_L_HI;
          end
        end
        OFC_L_SAV: begin
          link_data <= sync_byte(idx_reg, OFC_SAV_XY);
          link_valid <= 1'b1;
          idx_reg <= idx_reg + 2'h1;
          if (idx_reg == 2'h3) lstate_reg <= OFC_L_HI;
        end
        OFC_L_HI: begin
          link_data <= lw_reg[15:8];
          link_valid <= 1'b1;
          lstate_reg <= OFC_L_LO;
        end
        OFC_L_LO: begin
          link_data <= lw_reg[7:0];
          link_valid <= 1'b1;
          idx_reg <= 2'h0;
          lstate_reg <= (leol_reg && lsync_reg) ? OFC_L_EAV : OFC_L_IDLE;
        end
        OFC_L_EAV: begin
          link_data <= sync_byte(idx_reg, OFC_EAV_XY);
          link_valid <= 1'b1;
          idx_reg <= idx_reg + 2'h1;
          if (idx_reg == 2'h3) lstate_reg <= OFC_L_IDLE;
        end
        default: begin
          lstate_reg <= OFC_L_IDLE;
          link_valid <= 1'b0;
        end
      endcase
    end
  end

  //==========================================================================
  // checks
  logic plain;
  assign plain = !bypass_on && !bayer_on && !ramp_on && !shift_on && !sync_on;
  sequence sav_s;
    link_valid && link_data == 8'hFF ##1 link_data == 8'h00 ##1
    link_data == 8'h00 ##1 link_data == OFC_SAV_XY;
  endsequence
  sequence pair_s(logic [15:0] w);
    link_valid && link_data == w[15:8] ##1 link_valid && link_data == w[7:0];
  endsequence
  reset_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_seen_reg |-> fmt_reg == OFC_FMT_RESET) else $error("format reset value lost");
  reserved_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_we && reg_addr == OFC_FMT_ADDR |=> ##1 reg_re && reg_addr == OFC_FMT_ADDR |=>
    reg_rdata == fmt_reg) else $error("format readback wrong");
  bayer_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && bayer_on && !bypass_on |=> xw_reg[15:8] == $past(pix_bayer[RAW_W-1:RAW_W-8]))
    else $error("processed bayer not sent");
  bypass_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && bypass_on |=> xw_reg == {$past(pix_raw[RAW_W-1:RAW_W-8]),
    8'($past(pix_raw[RAW_W-9:0]))}) else $error("raw bypass packing wrong");
  rgb565_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && plain && rgb_on && rgb_mode == OFC_RGB565 |=>
    xw_reg == {$past(pix_r[7:3]), $past(pix_g[7:2]), $past(pix_b[7:3])})
    else $error("565 packing wrong");
  ycc_word_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && plain && !rgb_on |=> xw_reg == {$past(pix_c), $past(pix_y)})
    else $error("ycbcr packing wrong");
  ramp_col_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && ramp_mode == OFC_RAMP_COL && !bypass_on && !bayer_on && !rgb_on &&
    !shift_on && !sync_on && pix_sol |=> xw_reg[7:0] == 8'h00)
    else $error("column ramp not zero at line start");
  shift_up_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept && shift_on && !ramp_on && !sync_on && !bypass_on && !bayer_on && !rgb_on
    |=> xw_reg[2:0] == 3'h0 && xw_reg[7:3] == $past(pix_y[4:0]))
    else $error("shift up wrong");
  stats_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    accept |=> stat_valid && stat_r == $past(pix_r) && stat_b == $past(pix_b))
    else $error("statistics tap stopped");
  sav_order_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    lstate_reg == OFC_L_IDLE && new_word && xsol_reg && xsync_reg |=> ##1 sav_s)
    else $error("line start code wrong");
  no_code_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    lstate_reg == OFC_L_IDLE && new_word && !xsync_reg |=> ##1 pair_s(lw_reg))
    else $error("unexpected code or missing pixel bytes");
  two_bytes_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    lstate_reg == OFC_L_HI |=> pair_s($past(lw_reg)) ##1 lstate_reg != OFC_L_LO)
    else $error("pixel not two bytes");
  inv_follow_a: assert property (@(posedge link_clk) disable iff (!rst_n)
    fmt_reg[OFC_INV_BIT] [*3] |-> inv_s2_reg) else $error("clock inversion not applied");
endmodule

/* File: verif/ofc_host_model.sv */
// host capture model: takes link bytes on the receive edge of the pixel clock
`timescale 1ns/10ps
module ofc_host_model (
  // link from the device
  input wire logic output_pixel_clock,
  input wire logic [7:0] link_data,
  input wire logic link_valid,
  // capture setup
  input wire logic rst_n,
  input wire logic cap_inv
);
  import ofc_pkg::*;
  //==========================================================================
  // capture
  // bytes with valid low are dropped: the line is undefined between bytes
  logic [7:0] rx_q[$];
  // inversion clear: the device launches on rising, so take on falling
  always @(negedge output_pixel_clock) begin
    if (rst_n && !cap_inv && link_valid) begin
      rx_q.push_back(link_data);
    end
  end
  // inversion set: the device launches on falling, so take on rising
  always @(posedge output_pixel_clock) begin
    if (rst_n && cap_inv && link_valid) begin
      rx_q.push_back(link_data);
    end
  end
endmodule

/* File: verif/ofc_format_tb_top.sv */
// testbench for the context b output format block
`timescale 1ns/10ps
module ofc_format_tb_top;
  import ofc_pkg::*;
  //==========================================================================
  // signals
  logic clk, rst_n, link_clk, reg_we, reg_re, pix_valid, pix_sof, pix_sol, pix_eol, cap_inv;
  logic [8:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [9:0] pix_raw, pix_bayer;
  logic [7:0] pix_r, pix_g, pix_b, pix_y, pix_c, stat_r, stat_g, stat_b, link_data;
  logic pix_ready, stat_valid, output_pixel_clock, link_valid;
  int n_mismatch, cmp_count;
  logic [7:0] exp_q[$];
  logic [15:0] cfgs [11] = '{16'h0200, 16'h3200, 16'h0300, 16'h0340, 16'h0380, 16'h03C0,
    16'h4200, 16'h0600, 16'h4600, 16'h0208, 16'h0308};

  always #2 clk = ~clk;

  ofc_format #(.RAW_W(10), .CNT_W(8)) dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_sof(pix_sof),
    .pix_sol(pix_sol), .pix_eol(pix_eol), .pix_raw(pix_raw), .pix_bayer(pix_bayer),
    .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b), .pix_y(pix_y), .pix_c(pix_c),
    .stat_valid(stat_valid), .stat_r(stat_r), .stat_g(stat_g), .stat_b(stat_b),
    .output_pixel_clock(output_pixel_clock), .link_data(link_data), .link_valid(link_valid));

  ofc_host_model host (.output_pixel_clock(output_pixel_clock), .link_data(link_data),
    .link_valid(link_valid), .rst_n(rst_n), .cap_inv(cap_inv));

  //==========================================================================
  // tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    n_mismatch++;
    $display("BAD %s expected done seen timeout", what);
    give_verdict();
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] e, input string what);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    check(what, reg_rdata, e);
  endtask

  // the source holds the pixel while ready is low, as the stream requires
  task automatic send(input logic sof, input logic sol, input logic eol);
    int k;
    @(posedge clk);
    pix_valid <= 1'b1;
    pix_sof <= sof;
    pix_sol <= sol;
    pix_eol <= eol;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!pix_ready && k < 400);
    if (!pix_ready) timed_out("pix_ready");
    @(posedge clk);
    pix_valid <= 1'b0;
    @(negedge clk);
    check("stat_valid", {15'h0000, stat_valid}, 16'h0001);
    check("stat_r", {8'h00, stat_r}, {8'h00, pix_r});
    check("stat_gb", {stat_g, stat_b}, {pix_g, pix_b});
  endtask

  task automatic wait_n(input int n, input string what);
    int k;
    k = 0;
    while (host.rx_q.size() < n && k < 200) begin
      @(posedge link_clk);
      k++;
    end
    if (host.rx_q.size() < n) timed_out(what);
    repeat (4) @(posedge link_clk);
  endtask

  // nothing may arrive beyond the bytes expected
  task automatic expect_bytes(input string what);
    wait_n(exp_q.size(), what);
    check({what, " count"}, 16'(host.rx_q.size()), 16'(exp_q.size()));
    while (exp_q.size() > 0 && host.rx_q.size() > 0) begin
      check(what, {8'h00, host.rx_q.pop_front()}, {8'h00, exp_q.pop_front()});
    end
    host.rx_q.delete();
    exp_q.delete();
  endtask

  task automatic push_word(input logic [15:0] v);
    exp_q.push_back(v[15:8]);
    exp_q.push_back(v[7:0]);
  endtask

  function automatic logic [15:0] pack(input logic [15:0] cfg);
    logic [7:0] r, g, b, y, c;
    r = cfg[3] ? {pix_r[4:0], 3'h0} : pix_r;
    g = cfg[3] ? {pix_g[4:0], 3'h0} : pix_g;
    b = cfg[3] ? {pix_b[4:0], 3'h0} : pix_b;
    y = cfg[3] ? {pix_y[4:0], 3'h0} : pix_y;
    c = cfg[3] ? {pix_c[4:0], 3'h0} : pix_c;
    if (cfg[10]) return {pix_raw[9:2], 6'h00, pix_raw[1:0]};
    if (cfg[14]) return {pix_bayer[9:2], 6'h00, pix_bayer[1:0]};
    if (!cfg[8]) return {c, y};
    case (cfg[7:6])
      2'h0: return {r[7:3], g[7:2], b[7:3]};
      2'h1: return {1'h0, r[7:3], g[7:3], b[7:3]};
      2'h2: return {r[7:4], g[7:4], b[7:4], 4'h0};
      default: return {4'h0, r[7:4], g[7:4], b[7:4]};
    endcase
  endfunction

  //==========================================================================
  // link clock: odd phase offset keeps its edges clear of the system clock
  initial begin
    link_clk = 1'b0;
    #0.7;
    forever #62.5 link_clk = ~link_clk;
  end

  //==========================================================================
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {reg_we, reg_re, pix_valid, pix_sof, pix_sol, pix_eol} = 6'h00;
    reg_addr = 9'h000;
    reg_wdata = 16'h0000;
    cap_inv = 1'b1;
    {pix_r, pix_g, pix_b, pix_y, pix_c} = 40'hA53C965AC3;
    pix_raw = 10'h2B7;
    pix_bayer = 10'h1D4;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (2) @(posedge link_clk);
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("pclk default", {15'h0000, output_pixel_clock}, {15'h0000, ~link_clk});
    rd(OFC_FMT_ADDR, OFC_FMT_RESET, "fmt reset");
    wr(9'h100, 16'hFFFF);
    rd(9'h100, 16'h0000, "unmapped read");
    rd(OFC_FMT_ADDR, OFC_FMT_RESET, "fmt kept");
    wr(OFC_FMT_ADDR, 16'h3200);
    rd(OFC_FMT_ADDR, 16'h3200, "undefined bits");
    $display("test registers done");
    foreach (cfgs[i]) begin
      wr(OFC_FMT_ADDR, cfgs[i]);
      push_word(pack(cfgs[i]));
      send(1'b0, 1'b0, 1'b0);
      expect_bytes("format word");
    end
    $display("test formats done");
    wr(OFC_FMT_ADDR, 16'h0A00);
    exp_q = '{OFC_PRE_FF, OFC_PRE_00, OFC_PRE_00, OFC_SAV_XY};
    push_word(pack(16'h0A00));
    exp_q = {exp_q, OFC_PRE_FF, OFC_PRE_00, OFC_PRE_00, OFC_EAV_XY};
    send(1'b1, 1'b1, 1'b1);
    expect_bytes("sync codes");
    wr(OFC_FMT_ADDR, 16'h0200);
    push_word(pack(16'h0200));
    send(1'b1, 1'b1, 1'b1);
    expect_bytes("no sync codes");
    $display("test sync done");
    wr(OFC_FMT_ADDR, 16'h0210);
    push_word(16'h0000);
    push_word(16'h0101);
    send(1'b0, 1'b1, 1'b0);
    send(1'b0, 1'b0, 1'b1);
    rd(OFC_STAT_ADDR, 16'h0201, "status busy");
    expect_bytes("column ramp");
    for (int m = 2; m < 4; m++) begin
      wr(OFC_FMT_ADDR, 16'h0200 | 16'(m << 4));
      send(1'b1, 1'b1, 1'b0);
      wait_n(2, "ramp bytes");
      check("ramp hi", {8'h00, host.rx_q[0]}, (m == 2) ? 16'h0000 : 16'h0004);
      check("ramp lo", {8'h00, host.rx_q[1]}, (m == 2) ? 16'h0000 : 16'h0004);
      host.rx_q.delete();
    end
    rd(OFC_STAT_ADDR, 16'h0400, "status idle");
    $display("test ramp done");
    cap_inv = 1'b0;
    wr(OFC_FMT_ADDR, 16'h0000);
    repeat (4) @(posedge link_clk);
    @(negedge clk);
    check("pclk plain", {15'h0000, output_pixel_clock}, {15'h0000, link_clk});
    push_word(pack(16'h0000));
    send(1'b0, 1'b1, 1'b1);
    expect_bytes("plain clock");
    $display("test pixel clock done");
    give_verdict();
  end
endmodule
